// File: src/psic_pkg.sv
// package: constants for the phy status and interrupt control block
package psic_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_SUMMARY   = 8'h00;
  localparam logic [7:0] OFS_IRQ_CTRL  = 8'h04;
  localparam logic [7:0] OFS_EVENT     = 8'h08;
  localparam logic [7:0] OFS_BLK_STS   = 8'h0c;
  localparam logic [7:0] OFS_BLK_MASK  = 8'h10;

  // ------------------------------------------------------------------
  // summary status bit positions
  // ------------------------------------------------------------------
  localparam int SUM_LINK     = 0;
  localparam int SUM_SPEED10  = 1;
  localparam int SUM_DUPLEX   = 2;
  localparam int SUM_LOOPBACK = 3;
  localparam int SUM_AN_DONE  = 4;
  localparam int SUM_JABBER   = 5;

  // ------------------------------------------------------------------
  // interrupt control bit positions and reset value
  // ------------------------------------------------------------------
  localparam int CTL_PIN_OE   = 0;
  localparam int CTL_GLOBAL   = 1;
  localparam int CTL_TEST     = 2;
  localparam int CTL_MAP_SEL  = 3;
  localparam logic [3:0] CTL_RESET = 4'h0;

  // ------------------------------------------------------------------
  // event status bits; enable bit sits ENABLE_SHIFT lower
  // ------------------------------------------------------------------
  localparam int EV_HALF_FULL = 9;
  localparam int EV_AN_DONE   = 10;
  localparam int EV_DUP_OR_TS = 11;
  localparam int EV_SPEED     = 12;
  localparam int EV_LINK      = 13;
  localparam int EV_ENERGY    = 14;
  localparam int EV_QUALITY   = 15;
  localparam int ENABLE_SHIFT = 8;
  localparam logic [15:0] EV_USED    = 16'hfe00;
  localparam logic [15:0] EN_USED    = 16'h00fe;
  localparam logic [15:0] EV_RESET   = 16'h0000;

  // ------------------------------------------------------------------
  // block-level sticky status bits
  // ------------------------------------------------------------------
  localparam int BLK_IRQ_RISE = 0;
  localparam int BLK_LINK_CHG = 1;
  localparam int BLK_AN_DONE  = 2;
  localparam logic [2:0] BLK_RESET = 3'h0;

  // ------------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : psic_pkg

// File: src/psic_event_latch.sv
// sticky event latch, cleared by a read strobe
`timescale 1ns/100ps
module psic_event_latch
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [15:0] set_vec,
  input  wire logic        clear_all,
  output logic      [15:0] status
);

  // ------------------------------------------------------------------
  // latch
  // ------------------------------------------------------------------
  // set always wins
  always_ff @(posedge clock)
  begin
    if (!rstn)
      status <= psic_pkg::EV_RESET;
    else if (ce)
    begin
      if (clear_all)
        status <= set_vec & psic_pkg::EV_USED;
      else
        status <= (status | set_vec) & psic_pkg::EV_USED;
    end
  end

endmodule : psic_event_latch

// File: src/psic_top.sv
// phy summary status and interrupt control with an axi4-lite slave
//
// Contract
// - summary bit 5 shows jabber; meaningful only at 10 Mb/s.
// - jabber bit mirrors basic status; reading summary never clears it.
// - bit 4 shows auto-negotiation complete; read-only, resets to 0.
// - bit 3 is 1 while loopback enabled, 0 in normal operation.
// - bit 2 shows resolved duplex, 1 full, 0 half.
// - bit 1 shows resolved speed, 1 for 10, 0 for 100 Mb/s.
// - bit 0 is 1 with valid link at 10 or 100, else 0.
// - link bit mirrors basic status; reading summary never clears it.
// - control bits 15 to 4 ignore writes and read zero.
// - map select 1 puts time-sync at 11, speed-or-duplex at 12.
// - map select 0 puts duplex at 11, speed at 12.
// - test bit set keeps generating interrupts until cleared; here it does so only while control bit 1 is also set.
// - sources: quality, energy, link, speed, duplex, negotiation, half-full.
// - control bit 1 globally gates event interrupts; resets to 0.
// - control bit 0 makes shared pin interrupt output, else powerdown input.
// - event bits set even when disabled; cleared by reading them.
`timescale 1ns/100ps
module psic_top
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // phy state levels
  input  wire logic        jabber,
  input  wire logic        an_complete,
  input  wire logic        loopback,
  input  wire logic        full_duplex,
  input  wire logic        speed10,
  input  wire logic        link_up,
  input  wire logic        stats_half_full,
  // phy event pulses
  input  wire logic        link_quality_event,
  input  wire logic        energy_detect_event,
  input  wire logic        time_sync_event,
  // shared powerdown or interrupt pin
  input  wire logic        powerdown_or_irq_pin_i,
  output logic             powerdown_or_irq_pin_o,
  output logic             powerdown_or_irq_pin_oe,
  output logic             powerdown_req,
  // block interrupt
  output logic             irq
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] merge16(
    input logic [15:0] old_val,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old_val;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction : merge16

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        do_read;
  logic [3:0]  ctrl;
  logic [15:0] ev_enable;
  logic [15:0] ev_status;
  logic [15:0] ev_set;
  logic        ev_read;
  logic [2:0]  blk_sts;
  logic [2:0]  blk_mask;
  logic [2:0]  blk_set;
  logic        prev_link;
  logic        prev_speed;
  logic        prev_duplex;
  logic        prev_an;
  logic        prev_half;
  logic        prev_irq;
  logic        speed_chg;
  logic        duplex_chg;
  logic        link_chg;
  logic        an_done_evt;
  logic        half_evt;
  logic        pending;
  logic        phy_irq;
  logic [15:0] summary;
  logic [31:0] next_rdata;
  logic        next_rerr;

  // ------------------------------------------------------------------
  // bus handshakes
  // ------------------------------------------------------------------
  // ready drops with ce so nothing is taken while frozen
  assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;
  assign do_read       = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (ce)
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= psic_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          psic_pkg::OFS_SUMMARY,
          psic_pkg::OFS_IRQ_CTRL,
          psic_pkg::OFS_EVENT,
          psic_pkg::OFS_BLK_STS,
          psic_pkg::OFS_BLK_MASK: s_axi_bresp <= psic_pkg::RESP_OKAY;
          default:                s_axi_bresp <= psic_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // summary status
  // ------------------------------------------------------------------
  // levels mirrored straight, so no read can ever clear them
  always_comb
  begin
    summary = 16'h0000;
    summary[psic_pkg::SUM_LINK]     = link_up;
    summary[psic_pkg::SUM_SPEED10]  = speed10;
    summary[psic_pkg::SUM_DUPLEX]   = full_duplex;
    summary[psic_pkg::SUM_LOOPBACK] = loopback;
    summary[psic_pkg::SUM_AN_DONE]  = an_complete;
    summary[psic_pkg::SUM_JABBER]   = jabber;
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case (s_axi_araddr)
      psic_pkg::OFS_SUMMARY:  next_rdata[15:0] = summary;
      psic_pkg::OFS_IRQ_CTRL: next_rdata[3:0] = ctrl;
      psic_pkg::OFS_EVENT:    next_rdata[15:0] = ev_status | ev_enable;
      psic_pkg::OFS_BLK_STS:  next_rdata[2:0] = blk_sts;
      psic_pkg::OFS_BLK_MASK: next_rdata[2:0] = blk_mask;
      default:                next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= psic_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rerr ? psic_pkg::RESP_SLVERR
                                  : psic_pkg::RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // interrupt control register
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rstn)
      ctrl <= psic_pkg::CTL_RESET;
    else if (ce && do_write && aw_addr == psic_pkg::OFS_IRQ_CTRL)
      ctrl <= 4'(merge16({12'h000, ctrl}, w_data, w_strb));
  end

  // ------------------------------------------------------------------
  // event enables
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rstn)
      ev_enable <= psic_pkg::EV_RESET;
    else if (ce && do_write && aw_addr == psic_pkg::OFS_EVENT)
      ev_enable <= merge16(ev_enable, w_data, w_strb) & psic_pkg::EN_USED;
  end

  // ------------------------------------------------------------------
  // change detection
  // ------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      prev_link   <= 1'b0;
      prev_speed  <= 1'b0;
      prev_duplex <= 1'b0;
      prev_an     <= 1'b0;
      prev_half   <= 1'b0;
      prev_irq    <= 1'b0;
    end
    else if (ce)
    begin
      prev_link   <= link_up;
      prev_speed  <= speed10;
      prev_duplex <= full_duplex;
      prev_an     <= an_complete;
      prev_half   <= stats_half_full;
      prev_irq    <= phy_irq;
    end
  end

  assign link_chg    = link_up ^ prev_link;
  assign speed_chg   = speed10 ^ prev_speed;
  assign duplex_chg  = full_duplex ^ prev_duplex;
  assign an_done_evt = an_complete & ~prev_an;
  assign half_evt    = stats_half_full & ~prev_half;

  // ------------------------------------------------------------------
  // event status
  // ------------------------------------------------------------------
  always_comb
  begin
    ev_set = 16'h0000;
    ev_set[psic_pkg::EV_QUALITY]   = link_quality_event;
    ev_set[psic_pkg::EV_ENERGY]    = energy_detect_event;
    ev_set[psic_pkg::EV_LINK]      = link_chg;
    ev_set[psic_pkg::EV_AN_DONE]   = an_done_evt;
    ev_set[psic_pkg::EV_HALF_FULL] = half_evt;
    if (ctrl[psic_pkg::CTL_MAP_SEL])
    begin
      ev_set[psic_pkg::EV_DUP_OR_TS] = time_sync_event;
      ev_set[psic_pkg::EV_SPEED]     = speed_chg | duplex_chg;
    end
    else
    begin
      ev_set[psic_pkg::EV_DUP_OR_TS] = duplex_chg;
      ev_set[psic_pkg::EV_SPEED]     = speed_chg;
    end
  end

  assign ev_read = do_read && s_axi_araddr == psic_pkg::OFS_EVENT;

  psic_event_latch u_latch
  (
    .clock     (clock),
    .rstn      (rstn),
    .ce        (ce),
    .set_vec   (ev_set),
    .clear_all (ev_read),
    .status    (ev_status)
  );

  // ------------------------------------------------------------------
  // interrupt generation
  // ------------------------------------------------------------------
  // only enabled events count
  assign pending = |(ev_status & (ev_enable << psic_pkg::ENABLE_SHIFT));
  assign phy_irq = ctrl[psic_pkg::CTL_GLOBAL]
                 & (pending | ctrl[psic_pkg::CTL_TEST]);

  // pin direction from control bit 0
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      powerdown_or_irq_pin_o  <= 1'b1;
      powerdown_or_irq_pin_oe <= 1'b0;
      powerdown_req           <= 1'b0;
    end
    else if (ce)
    begin
      powerdown_or_irq_pin_o  <= ~phy_irq;
      powerdown_or_irq_pin_oe <= ctrl[psic_pkg::CTL_PIN_OE];
      powerdown_req           <= ~ctrl[psic_pkg::CTL_PIN_OE]
                               & ~powerdown_or_irq_pin_i;
    end
  end

  // ------------------------------------------------------------------
  // block sticky status and mask
  // ------------------------------------------------------------------
  always_comb
  begin
    blk_set = 3'h0;
    blk_set[psic_pkg::BLK_IRQ_RISE] = phy_irq & ~prev_irq;
    blk_set[psic_pkg::BLK_LINK_CHG] = link_chg;
    blk_set[psic_pkg::BLK_AN_DONE]  = an_done_evt;
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (!rstn)
      blk_sts <= psic_pkg::BLK_RESET;
    else if (ce)
    begin
      if (do_write && aw_addr == psic_pkg::OFS_BLK_STS && w_strb[0])
        blk_sts <= (blk_sts & ~w_data[2:0]) | blk_set;
      else
        blk_sts <= blk_sts | blk_set;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      blk_mask <= psic_pkg::BLK_RESET;
    else if (ce && do_write && aw_addr == psic_pkg::OFS_BLK_MASK
             && w_strb[0])
      blk_mask <= w_data[2:0];
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(blk_sts & blk_mask);
  end

endmodule : psic_top

// File: dv/psic_top_asserts.sv
// checker: port properties of the status and interrupt block
`timescale 1ns/100ps
module psic_top_asserts
(
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        jabber,
  input wire logic        an_complete,
  input wire logic        loopback,
  input wire logic        full_duplex,
  input wire logic        speed10,
  input wire logic        link_up,
  input wire logic        powerdown_or_irq_pin_oe,
  input wire logic        powerdown_req,
  input wire logic        irq
);
  logic [5:0] lv;
  logic       rd_go;
  assign lv = {jabber, an_complete, loopback, full_duplex, speed10, link_up};
  assign rd_go = s_axi_arvalid && s_axi_arready && ce;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // ------------------------------------------------------------------
  // bus timing
  // ------------------------------------------------------------------
  a_read_answer:
  assert property (rd_go |=> s_axi_rvalid)
    else $error("read answer missing");
  a_write_answer:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready && ce |-> ##2 s_axi_bvalid)
    else $error("write answer missing");
  a_read_refuse:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refuse:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_upper_zero:
  assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_unmapped_read:
  assert property (rd_go && s_axi_araddr > psic_pkg::OFS_BLK_MASK |=>
    s_axi_rresp == psic_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");

  // ------------------------------------------------------------------
  // register contents
  // ------------------------------------------------------------------
  a_summary_bits:
  assert property (rd_go && s_axi_araddr == psic_pkg::OFS_SUMMARY
    && $stable(lv) |=> s_axi_rdata == {26'h0, $past(lv)}
    && s_axi_rresp == psic_pkg::RESP_OKAY)
    else $error("summary read differs from levels");
  a_ctl_reserved:
  assert property (rd_go && s_axi_araddr == psic_pkg::OFS_IRQ_CTRL
    |=> s_axi_rdata[31:4] == 28'h0)
    else $error("control reserved bits not zero");
  a_powerdown_gate:
  assert property (powerdown_req |-> !powerdown_or_irq_pin_oe)
    else $error("powerdown while pin is output");

  c_summary_read: cover property (rd_go && s_axi_araddr == 8'h00);
  c_irq_rise: cover property ($rose(irq));
  c_powerdown: cover property (powerdown_req);
endmodule : psic_top_asserts

bind psic_top psic_top_asserts i_psic_top_asserts (.*);

// File: dv/psic_axi_master.sv
// partner: axi4-lite management master for the block
`timescale 1ns/100ps
module psic_axi_master
(
  input  wire logic        clock,
  output logic      [7:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [7:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  output logic             hung
);
  // ------------------------------------------------------------------
  // idle levels; answers are always accepted at once
  // ------------------------------------------------------------------
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid, hung} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
  end

  // released lines show inverted values, never the stale ones
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic pa;
    logic pw;
    begin
      n = 0;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
        @(posedge clock);
        n++;
        if (pa && s_axi_awready)
        begin
          pa = 1'b0;
          s_axi_awvalid <= 1'b0;
          s_axi_awaddr <= ~a;
        end
        if (pw && s_axi_wready)
        begin
          pw = 1'b0;
          s_axi_wvalid <= 1'b0;
          s_axi_wdata <= ~d;
        end
      end
      while (!s_axi_bvalid && n < 64);
      if (n >= 64)
        hung <= 1'b1;
    end
  endtask : put

  task automatic get(input logic [7:0] a);
    int   n;
    logic p;
    begin
      n = 0;
      p = 1'b1;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do
      begin
        @(posedge clock);
        n++;
        if (p && s_axi_arready)
        begin
          p = 1'b0;
          s_axi_arvalid <= 1'b0;
          s_axi_araddr <= ~a;
        end
      end
      while (!s_axi_rvalid && n < 64);
      if (n >= 64)
        hung <= 1'b1;
    end
  endtask : get
endmodule : psic_axi_master

// File: dv/psic_top_test.sv
// testbench: registers, event mapping and interrupt pin of the block
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module psic_top_test;
  logic        clock, rstn, ce, time_sync_event, pd_drv, hung;
  logic        stats_half_full, link_quality_event, energy_detect_event;
  logic [5:0]  lv;
  wire logic   jabber, an_complete, loopback, full_duplex, speed10, link_up;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, eb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, powerdown_or_irq_pin_o;
  logic        powerdown_or_irq_pin_oe, powerdown_req, irq;
  wire logic   powerdown_or_irq_pin_i;
  logic [34:0] e;
  logic [34:0] rq[$];
  logic [1:0]  bq[$];
  int          error_cnt, n_checks;

  assign {jabber, an_complete, loopback, full_duplex, speed10, link_up} = lv;
  // shared pin: block drives it only while its enable is high
  assign powerdown_or_irq_pin_i = powerdown_or_irq_pin_oe ?
    powerdown_or_irq_pin_o : pd_drv;

  psic_top i_psic_top
  (
    .*
  );
  psic_axi_master i_psic_axi_master (.*);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0, input bit k = 1'b1);
    rq.push_back({k, r, d});
    i_psic_axi_master.get(a);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    bq.push_back(r);
    i_psic_axi_master.put(a, d);
  endtask : wr

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------------
  // answer monitor
  // ------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
    begin
      e = rq.pop_front();
      if (e[34])
        `CHK({s_axi_rresp, s_axi_rdata}, e[33:0])
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
    begin
      eb = bq.pop_front();
      `CHK(s_axi_bresp, eb)
    end
  end

  always @(posedge hung)
  begin
    $display("ERROR %0t: bus wait ran out", $time);
    error_cnt++;
    close_out;
  end

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    {rstn, time_sync_event, lv, error_cnt, n_checks} = '0;
    {stats_half_full, link_quality_event, energy_detect_event} = 3'h0;
    {ce, pd_drv} = 2'b11;
    seed = 32'h2dd7;
    wt(16);
    rstn <= 1'b1;
    wt(1);
    for (int i = 0; i < 5; i++)
      rd(8'(i * 4), 32'h0);
    $display("reset values done");
    // software trusts speed and duplex only once link is settled
    for (int i = 0; i < 8; i++)
    begin
      lv <= 6'(rnd());
      wt(3);
      rd(psic_pkg::OFS_SUMMARY, {26'h0, lv});
      rd(psic_pkg::OFS_SUMMARY, {26'h0, lv});
    end
    rd(psic_pkg::OFS_EVENT, 32'h0, 2'h0, 1'b0);
    wr(psic_pkg::OFS_SUMMARY, 32'h3f);
    rd(psic_pkg::OFS_SUMMARY, {26'h0, lv});
    wr(psic_pkg::OFS_IRQ_CTRL, 32'hffff_fff8);
    rd(psic_pkg::OFS_IRQ_CTRL, 32'h8);
    $display("summary and control done");
    for (int m = 0; m < 2; m++)
    begin
      wr(psic_pkg::OFS_IRQ_CTRL, 32'(m << 3));
      rd(psic_pkg::OFS_EVENT, 32'h0, 2'h0, 1'b0);
      time_sync_event <= 1'b1;
      lv[2] <= ~lv[2];
      wt(1);
      time_sync_event <= 1'b0;
      wt(3);
      rd(psic_pkg::OFS_EVENT, m ? 32'h1800 : 32'h0800);
      lv[1] <= ~lv[1];
      wt(3);
      rd(psic_pkg::OFS_EVENT, 32'h1000);
    end
    // remaining sources: quality and energy pulses, half-full rise
    {link_quality_event, energy_detect_event, stats_half_full} <= 3'h7;
    wt(1);
    {link_quality_event, energy_detect_event} <= 2'h0;
    wt(3);
    rd(psic_pkg::OFS_EVENT, 32'hc200);
    $display("event mapping done");
    wr(psic_pkg::OFS_BLK_STS, 32'h7);
    wr(psic_pkg::OFS_IRQ_CTRL, 32'h5);
    wt(4);
    `CHK(powerdown_or_irq_pin_o, 1'b1)
    `CHK(powerdown_or_irq_pin_oe, 1'b1)
    wr(psic_pkg::OFS_IRQ_CTRL, 32'h7);
    wt(20);
    `CHK(powerdown_or_irq_pin_o, 1'b0)
    `CHK(irq, 1'b0)
    rd(psic_pkg::OFS_BLK_STS, 32'h1);
    wr(psic_pkg::OFS_BLK_MASK, 32'h1);
    wt(4);
    `CHK(irq, 1'b1)
    wr(psic_pkg::OFS_BLK_STS, 32'h1);
    wt(4);
    `CHK(irq, 1'b0)
    wr(psic_pkg::OFS_IRQ_CTRL, 32'h3);
    wt(4);
    `CHK(powerdown_or_irq_pin_o, 1'b1)
    // event enable must be set before its interrupt is expected
    wr(psic_pkg::OFS_EVENT, 32'h20);
    lv[0] <= ~lv[0];
    wt(4);
    `CHK(powerdown_or_irq_pin_o, 1'b0)
    rd(psic_pkg::OFS_EVENT, 32'h2020);
    wt(4);
    `CHK(powerdown_or_irq_pin_o, 1'b1)
    $display("interrupt tests done");
    wr(8'h20, 32'h1, psic_pkg::RESP_SLVERR);
    rd(8'h20, 32'h0, psic_pkg::RESP_SLVERR);
    wr(psic_pkg::OFS_IRQ_CTRL, 32'h0);
    pd_drv <= 1'b0;
    wt(4);
    `CHK(powerdown_req, 1'b1)
    `CHK(powerdown_or_irq_pin_oe, 1'b0)
    // frozen while ce low: readies drop, request held, change waits
    ce <= 1'b0;
    pd_drv <= 1'b1;
    lv[0] <= ~lv[0];
    wt(4);
    `CHK(s_axi_arready, 1'b0)
    `CHK(powerdown_req, 1'b1)
    ce <= 1'b1;
    wt(1);
    rd(psic_pkg::OFS_EVENT, 32'h2020);
    $display("unmapped and powerdown done");
    close_out;
  end
endmodule : psic_top_test
